// >>> dv/digital_ramp_generator_test.sv
`timescale 1ns/1ps
`include "rgen_map.svh"
module digital_ramp_generator_test;
  import rgen_pkg::*;
  localparam int DIV = 4;
  localparam int P   = 2;
  localparam int N   = 3;
  logic        hclk, hresetn, hsel, hwrite, hreadyout_q, hresp_q;
  logic        ramp_active_q, dir_pin, hold_pin, upd_pin;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] phase_word_q;
  logic [11:0] amp_word_q;
  rgen_word_t  hwdata, hrdata_q, freq_word_q, rd, a, v, lo, rise, fall, pf, ppa;
  int          bad_count, n_checks, cyc, n, d;

  // A short core divider keeps every step interval brief.
  rgen_ramp #(.CORE_DIV(DIV)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_q), .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q),
    .hresp_q(hresp_q), .ramp_direction_pin(dir_pin), .ramp_hold_pin(hold_pin),
    .io_update_pin(upd_pin), .freq_word_q(freq_word_q),
    .phase_word_q(phase_word_q), .amp_word_q(amp_word_q),
    .ramp_active_q(ramp_active_q)
  );
  rgen_host_pins host (.hclk(hclk), .dir_pin(dir_pin), .hold_pin(hold_pin), .upd_pin(upd_pin));

  // Free-running clock at 25 MHz.
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  // Watchdog; a hang counts as a failure and still reaches the report.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input rgen_word_t got, input rgen_word_t exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer; waits on hready in both phases.
  task automatic bus(input logic w, input logic [5:0] idx, input rgen_word_t wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout_q !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout_q !== 1'b1);
    rd = hrdata_q;
  endtask : bus

  // Syncs on one output change, then times the next one in clocks.
  task automatic step(output int k, output rgen_word_t dv);
    v = freq_word_q;
    while (freq_word_q === v) @(posedge hclk);
    v = freq_word_q;
    k = 0;
    while (freq_word_q === v) begin
      @(posedge hclk);
      k++;
    end
    dv = freq_word_q - v;
  endtask : step

  // Expected parameter k (0 freq, 1 phase, 2 amplitude) for destination s.
  function automatic rgen_word_t expo(logic [1:0] s, int k);
    case (k)
      0:       return (s == 2'b00) ? a : pf;
      1:       return (s == 2'b01) ? {16'h0, a[31:18], 2'b00} : {16'h0, ppa[15:0]};
      default: return s[1] ? {20'h0, a[31:20]} : {20'h0, ppa[27:16]};
    endcase
  endfunction : expo

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, bad_count, n_checks, cyc} = '0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(63121));
    bus(0, `RGEN_IDX_RATE, 0);
    chk(rd, `RGEN_RATE_RST);
    bus(0, `RGEN_IDX_UPPER, 0);
    chk(rd, `RGEN_UPPER_RST);
    bus(0, 6'h3f, 0);
    chk(rd, 0);
    chk({31'h0, hresp_q}, 0);
    $display("test reset done");
    lo   = $urandom & 32'h00ff_ffff;
    rise = $urandom_range(16'hffff, 1);
    fall = $urandom_range(rise, 1);
    pf   = $urandom;
    ppa  = $urandom;
    bus(1, `RGEN_IDX_LOWER, lo);
    bus(1, `RGEN_IDX_RISE, rise);
    bus(1, `RGEN_IDX_FALL, fall);
    bus(1, `RGEN_IDX_RATE, {16'(N), 16'(P)});
    bus(1, `RGEN_IDX_PROF_FREQ, pf);
    bus(1, `RGEN_IDX_PROF_PA, ppa);
    bus(1, `RGEN_IDX_CTRL2, 32'h0008_0000);
    host.set_pins(1, 0);
    repeat (20) @(posedge hclk);
    chk({31'h0, ramp_active_q}, 0);
    host.update();
    chk({31'h0, ramp_active_q}, 1);
    step(n, v);
    chk(n, P * DIV);
    chk(v, rise);
    host.set_pins(0, 0);
    step(n, v);
    chk(n, N * DIV);
    chk(v, -fall);
    $display("test slopes done");
    host.set_pins(0, 1);
    v = freq_word_q;
    repeat (40) @(posedge hclk);
    chk(freq_word_q, v);
    bus(0, `RGEN_IDX_RAMP_OUT, 0);
    a = rd;
    chk(freq_word_q, a);
    for (d = 1; d <= 4; d++) begin
      bus(1, `RGEN_IDX_CTRL2, 32'h0008_0000 | ((d & 3) << 20));
      host.update();
      chk(freq_word_q, expo(2'(d), 0));
      chk({16'h0, phase_word_q}, expo(2'(d), 1));
      chk({20'h0, amp_word_q}, expo(2'(d), 2));
    end
    $display("test hold and routing done");
    bus(1, `RGEN_IDX_UPPER, a + (rise >> 1));
    host.set_pins(1, 0);
    repeat (P * DIV * 4) @(posedge hclk);
    chk(freq_word_q, a + (rise >> 1));
    bus(1, `RGEN_IDX_UPPER, `RGEN_UPPER_RST);
    bus(1, `RGEN_IDX_CTRL1, 32'h0000_1000);
    host.update();
    repeat (10) @(posedge hclk);
    chk(freq_word_q, lo);
    bus(1, `RGEN_IDX_CTRL1, 32'h0000_8000);
    host.update();
    step(n, v);
    chk(n, P * DIV);
    chk(v, rise);
    // Autoclear under hold: the ramp drops to the lower limit and stays frozen there.
    host.set_pins(1, 1);
    bus(1, `RGEN_IDX_CTRL1, 32'h0000_4000);
    host.update();
    chk(freq_word_q, lo);
    bus(0, `RGEN_IDX_STATUS, 0);
    chk(rd, 32'h0000_002e);
    bus(1, `RGEN_IDX_CTRL2, 0);
    host.update();
    chk({31'h0, ramp_active_q}, 0);
    $display("test limit and clear done");
    summarize();
  end
endmodule : digital_ramp_generator_test

// >>> dv/rgen_host_pins.sv
`timescale 1ns/1ps
// Host model of the ramp pins; every level is held for several clocks so the
// two-stage synchronisers inside the device always catch it.
module rgen_host_pins (
  // Clock.
  input  wire logic hclk,
  // Pins towards the device.
  output logic      dir_pin,
  output logic      hold_pin,
  output logic      upd_pin
);
  // Quiet levels before the first request.
  initial begin
    dir_pin  = 1'b0;
    hold_pin = 1'b0;
    upd_pin  = 1'b0;
  end
  // Sets direction and hold, then keeps them for four clocks.
  task automatic set_pins(input logic d, input logic h);
    @(posedge hclk);
    dir_pin  <= d;
    hold_pin <= h;
    repeat (4) @(posedge hclk);
  endtask : set_pins
  // One update strobe; the trailing gap keeps strobes well apart.
  task automatic update();
    @(posedge hclk);
    upd_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    upd_pin <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : update
endmodule : rgen_host_pins

// >>> pkg/rgen_map.svh
`ifndef RGEN_MAP_SVH
`define RGEN_MAP_SVH
// Register indices; the byte address is four times the index.
`define RGEN_IDX_CTRL1      6'h00
`define RGEN_IDX_CTRL2      6'h01
`define RGEN_IDX_LOWER      6'h04
`define RGEN_IDX_UPPER      6'h05
`define RGEN_IDX_RISE       6'h06
`define RGEN_IDX_FALL       6'h07
`define RGEN_IDX_RATE       6'h08
`define RGEN_IDX_PROF_FREQ  6'h0b
`define RGEN_IDX_PROF_PA    6'h0c
`define RGEN_IDX_RAMP_OUT   6'h0f
`define RGEN_IDX_STATUS     6'h10
// Word index position inside haddr.
`define RGEN_ADDR_HI        7
`define RGEN_ADDR_LO        2
// Control word fields.
`define RGEN_C1_RATE_RELOAD 15
`define RGEN_C1_AUTOCLR     14
`define RGEN_C1_CLR         12
`define RGEN_C2_ENABLE      19
`define RGEN_C2_DEST_HI     21
`define RGEN_C2_DEST_LO     20
// Interval register fields.
`define RGEN_RATE_P_HI      15
`define RGEN_RATE_P_LO      0
`define RGEN_RATE_N_HI      31
`define RGEN_RATE_N_LO      16
// Profile fields and destination slices.
`define RGEN_PROF_PH_HI     15
`define RGEN_PROF_PH_LO     0
`define RGEN_PROF_AM_HI     27
`define RGEN_PROF_AM_LO     16
`define RGEN_PHASE_HI       31
`define RGEN_PHASE_LO       18
`define RGEN_AMP_HI         31
`define RGEN_AMP_LO         20
// Reset values.
`define RGEN_ZERO_RST       32'h0000_0000
`define RGEN_UPPER_RST      32'hffff_ffff
`define RGEN_RATE_RST       32'h0001_0001
// Bus codes and timing.
`define RGEN_HTRANS_ACT_BIT 1
`define RGEN_HSIZE_WORD     3'h2
`define RGEN_CORE_DIV       24
`endif

// >>> pkg/rgen_pkg.sv
package rgen_pkg;
  // Destination of the ramp output.
  typedef enum logic [1:0] {
    RGEN_DEST_FREQ  = 2'b00,
    RGEN_DEST_PHASE = 2'b01,
    RGEN_DEST_AMP   = 2'b10
  } rgen_dest_t;
  // Accumulator state.
  typedef enum logic [1:0] {
    RGEN_ST_OFF   = 2'b00,
    RGEN_ST_CLEAR = 2'b01,
    RGEN_ST_RUN   = 2'b10
  } rgen_state_t;
  typedef logic [31:0] rgen_word_t;
endpackage : rgen_pkg

// >>> verilog/rgen_core_tick.sv
`timescale 1ns/1ps
module rgen_core_tick #(
  parameter int DIV = 24
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Gate and tick.
  input  wire logic en,
  output logic      tick_q
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;

  if (DIV < 2) begin : g_chk
    $error("rgen_core_tick: DIV must be at least 2");
  end

  // Divider stops and rests at zero while gated, which stands in for the clock gate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (!en) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == CW'(DIV - 1));
      cnt_q  <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule : rgen_core_tick

// >>> verilog/rgen_ramp.sv
`timescale 1ns/1ps
`include "rgen_map.svh"
module rgen_ramp
  import rgen_pkg::*;
#(
  parameter int CORE_DIV = `RGEN_CORE_DIV,
  parameter int RATE_W   = 16
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave.
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire rgen_pkg::rgen_word_t hwdata,
  input  wire logic             hready,
  output rgen_pkg::rgen_word_t  hrdata_q,
  output logic                  hreadyout_q,
  output logic                  hresp_q,
  // Ramp control pins.
  input  wire logic             ramp_direction_pin,
  input  wire logic             ramp_hold_pin,
  input  wire logic             io_update_pin,
  // Core parameters.
  output rgen_pkg::rgen_word_t  freq_word_q,
  output logic [15:0]           phase_word_q,
  output logic [11:0]           amp_word_q,
  output logic                  ramp_active_q
);
  import rgen_pkg::*;

  if (RATE_W != 16) begin : g_chk
    $error("rgen_ramp: interval fields are 16 bits wide");
  end

  // Destination decode, shared by routing and status.
  function automatic rgen_dest_t dest_decode(input logic [1:0] code);
    dest_decode = code[1] ? RGEN_DEST_AMP : (code[0] ? RGEN_DEST_PHASE : RGEN_DEST_FREQ);
  endfunction : dest_decode

  rgen_word_t  ctrl1_q, ctrl2_q, lower_q, upper_q, rise_q, fall_q, rate_q;
  rgen_word_t  prof_freq_q, prof_pa_q, acc_q, rd_mux;
  logic        wr_pend_q;
  logic [5:0]  wr_idx_q;
  logic [2:0]  pin_meta_q, pin_sync_q;
  logic        upd_prev_q, dir_prev_q, io_upd, dir_s, hold_s, dir_chg;
  logic        en_act_q, clr_act_q, autoclr_q;
  rgen_dest_t  dest_act_q;
  rgen_state_t st_q, st_d;
  logic        core_tick, expire, timer_load, en_rise, bus_ok;
  logic [RATE_W-1:0] ival, tmr_cnt;
  logic [32:0] sum33, diff33;

  // Pins come from outside the clock domain; two flops each before use.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_meta_q[i] <= 1'b0;
        pin_sync_q[i] <= 1'b0;
      end else begin
        pin_meta_q[i] <= (i == 0) ? ramp_direction_pin :
                         (i == 1) ? ramp_hold_pin : io_update_pin;
        pin_sync_q[i] <= pin_meta_q[i];
      end
    end
  end

  // Hold and direction changes mean nothing while the ramp is off.
  assign dir_s   = pin_sync_q[0];
  assign hold_s  = pin_sync_q[1] && en_act_q;
  assign io_upd  = pin_sync_q[2] && !upd_prev_q;
  assign dir_chg = en_act_q && (dir_s != dir_prev_q);

  // Edge history for the update and direction pins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_prev_q <= 1'b0;
      dir_prev_q <= 1'b0;
    end else begin
      upd_prev_q <= pin_sync_q[2];
      dir_prev_q <= dir_s;
    end
  end

  // Enable, clear and destination are shadowed and only land at an I/O update.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_act_q   <= 1'b0;
      clr_act_q  <= 1'b0;
      dest_act_q <= RGEN_DEST_FREQ;
    end else if (io_upd) begin
      en_act_q   <= ctrl2_q[`RGEN_C2_ENABLE];
      clr_act_q  <= ctrl1_q[`RGEN_C1_CLR];
      dest_act_q <= dest_decode(ctrl2_q[`RGEN_C2_DEST_HI:`RGEN_C2_DEST_LO]);
    end
  end

  // Autoclear holds the accumulator at the lower limit until the next core tick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      autoclr_q <= 1'b0;
    end else if (io_upd && ctrl1_q[`RGEN_C1_AUTOCLR]) begin
      autoclr_q <= 1'b1;
    end else if (core_tick) begin
      autoclr_q <= 1'b0;
    end
  end

  // Core clock as an enable that only runs while the ramp is on.
  rgen_core_tick #(.DIV(CORE_DIV)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (en_act_q),
    .tick_q  (core_tick)
  );

  // Timer reload sources and interval choice by slope.
  assign en_rise    = io_upd && ctrl2_q[`RGEN_C2_ENABLE] && !en_act_q;
  assign timer_load = en_rise || dir_chg ||
                      (en_act_q && io_upd && ctrl1_q[`RGEN_C1_RATE_RELOAD]);
  assign ival       = dir_s ? rate_q[`RGEN_RATE_P_HI:`RGEN_RATE_P_LO]
                            : rate_q[`RGEN_RATE_N_HI:`RGEN_RATE_N_LO];

  rgen_step_timer #(.W(RATE_W)) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick     (core_tick),
    .hold     (hold_s),
    .load     (timer_load),
    .load_val (ival),
    .expire_q (expire),
    .cnt_q    (tmr_cnt)
  );

  // State follows the active controls; clear wins over running.
  always_comb begin
    if (!en_act_q) begin
      st_d = RGEN_ST_OFF;
    end else if (clr_act_q || autoclr_q) begin
      st_d = RGEN_ST_CLEAR;
    end else begin
      st_d = RGEN_ST_RUN;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= RGEN_ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Step sums are kept at 33 bits so a wrap is seen as overshooting the limit.
  assign sum33  = {1'b0, acc_q} + {1'b0, rise_q};
  assign diff33 = {1'b0, acc_q} - {1'b0, fall_q};

  // Accumulator; the limits sit in its feedback path, so clear equals preset to lower.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= `RGEN_ZERO_RST;
    end else begin
      unique case (st_q)
        RGEN_ST_OFF, RGEN_ST_CLEAR: begin
          acc_q <= lower_q;
        end
        RGEN_ST_RUN: begin
          if (hold_s) begin
            acc_q <= acc_q;
          end else if (expire && dir_s) begin
            acc_q <= (sum33 > {1'b0, upper_q}) ? upper_q :
                     (sum33[31:0] < lower_q) ? lower_q : sum33[31:0];
          end else if (expire) begin
            acc_q <= (diff33[32] || diff33[31:0] < lower_q) ? lower_q :
                     (diff33[31:0] > upper_q) ? upper_q : diff33[31:0];
          end else if (acc_q > upper_q) begin
            acc_q <= upper_q;
          end else if (acc_q < lower_q) begin
            acc_q <= lower_q;
          end
        end
        default: begin
          acc_q <= lower_q;
        end
      endcase
    end
  end

  // Routing to the core; non-destination parameters come from the profile.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_word_q   <= `RGEN_ZERO_RST;
      phase_word_q  <= '0;
      amp_word_q    <= '0;
      ramp_active_q <= 1'b0;
    end else begin
      ramp_active_q <= en_act_q;
      freq_word_q   <= prof_freq_q;
      phase_word_q  <= prof_pa_q[`RGEN_PROF_PH_HI:`RGEN_PROF_PH_LO];
      amp_word_q    <= prof_pa_q[`RGEN_PROF_AM_HI:`RGEN_PROF_AM_LO];
      if (en_act_q) begin
        unique case (dest_act_q)
          RGEN_DEST_FREQ:  freq_word_q <= acc_q;
          RGEN_DEST_PHASE: phase_word_q <= {acc_q[`RGEN_PHASE_HI:`RGEN_PHASE_LO], 2'b00};
          RGEN_DEST_AMP:   amp_word_q <= acc_q[`RGEN_AMP_HI:`RGEN_AMP_LO];
          default:         freq_word_q <= prof_freq_q;
        endcase
      end
    end
  end

  // Only whole-word NONSEQ or SEQ transfers are served; other sizes are dropped silently.
  assign bus_ok = hsel && hready && htrans[`RGEN_HTRANS_ACT_BIT] && (hsize == `RGEN_HSIZE_WORD);

  // Read mux; unmapped indices read as zero.
  always_comb begin
    unique case (haddr[`RGEN_ADDR_HI:`RGEN_ADDR_LO])
      `RGEN_IDX_CTRL1:     rd_mux = ctrl1_q;
      `RGEN_IDX_CTRL2:     rd_mux = ctrl2_q;
      `RGEN_IDX_LOWER:     rd_mux = lower_q;
      `RGEN_IDX_UPPER:     rd_mux = upper_q;
      `RGEN_IDX_RISE:      rd_mux = rise_q;
      `RGEN_IDX_FALL:      rd_mux = fall_q;
      `RGEN_IDX_RATE:      rd_mux = rate_q;
      `RGEN_IDX_PROF_FREQ: rd_mux = prof_freq_q;
      `RGEN_IDX_PROF_PA:   rd_mux = prof_pa_q;
      `RGEN_IDX_RAMP_OUT:  rd_mux = acc_q;
      `RGEN_IDX_STATUS:    rd_mux = {24'h00_0000, dest_act_q, st_q, hold_s, dir_s, en_act_q,
                                     clr_act_q};
      default:             rd_mux = `RGEN_ZERO_RST;
    endcase
  end

  // Address phase: reads are sampled here so the data phase needs no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_idx_q    <= '0;
      hrdata_q    <= `RGEN_ZERO_RST;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (hready) begin
        wr_pend_q <= bus_ok && hwrite;
        wr_idx_q  <= haddr[`RGEN_ADDR_HI:`RGEN_ADDR_LO];
      end
      if (bus_ok && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Data phase writes; unmapped or read-only indices are ignored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q     <= `RGEN_ZERO_RST;
      ctrl2_q     <= `RGEN_ZERO_RST;
      lower_q     <= `RGEN_ZERO_RST;
      upper_q     <= `RGEN_UPPER_RST;
      rise_q      <= `RGEN_ZERO_RST;
      fall_q      <= `RGEN_ZERO_RST;
      rate_q      <= `RGEN_RATE_RST;
      prof_freq_q <= `RGEN_ZERO_RST;
      prof_pa_q   <= `RGEN_ZERO_RST;
    end else if (wr_pend_q) begin
      unique case (wr_idx_q)
        `RGEN_IDX_CTRL1:     ctrl1_q <= hwdata;
        `RGEN_IDX_CTRL2:     ctrl2_q <= hwdata;
        `RGEN_IDX_LOWER:     lower_q <= hwdata;
        `RGEN_IDX_UPPER:     upper_q <= hwdata;
        `RGEN_IDX_RISE:      rise_q <= hwdata;
        `RGEN_IDX_FALL:      fall_q <= hwdata;
        `RGEN_IDX_RATE:      rate_q <= hwdata;
        `RGEN_IDX_PROF_FREQ: prof_freq_q <= hwdata;
        `RGEN_IDX_PROF_PA:   prof_pa_q <= hwdata;
        default:             ;
      endcase
    end
  end

  // Checks on the ramp behaviour.
  sequence s_run_step_up;
    st_q == RGEN_ST_RUN && expire && !hold_s && dir_s && sum33 <= {1'b0, upper_q} &&
      sum33[31:0] >= lower_q;
  endsequence
  sequence s_run_step_down;
    st_q == RGEN_ST_RUN && expire && !hold_s && !dir_s && !diff33[32] &&
      diff33[31:0] >= lower_q && diff33[31:0] <= upper_q;
  endsequence

  tick_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !en_act_q |=> !core_tick)
    else $error("core tick while ramp disabled");
  core_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    core_tick && en_act_q && $past(en_act_q) |-> ##CORE_DIV (core_tick || !en_act_q))
    else $error("core tick period wrong");
  freq_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_act_q && dest_act_q == RGEN_DEST_FREQ |=> freq_word_q == $past(acc_q))
    else $error("frequency not taken from ramp");
  phase_align_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_act_q && dest_act_q == RGEN_DEST_PHASE |=> phase_word_q[15:2] == $past(acc_q[31:18]))
    else $error("phase slice wrong");
  amp_align_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_act_q && dest_act_q == RGEN_DEST_AMP |=> amp_word_q == $past(acc_q[31:20]))
    else $error("amplitude slice wrong");
  profile_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dest_act_q == RGEN_DEST_FREQ |=> amp_word_q == $past(prof_pa_q[27:16]))
    else $error("amplitude not from profile");
  rise_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_run_step_up |=> acc_q == $past(acc_q) + $past(rise_q))
    else $error("rising step not added");
  fall_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_run_step_down |=> acc_q == $past(acc_q) - $past(fall_q))
    else $error("falling step not subtracted");
  hold_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == RGEN_ST_RUN && hold_s |=> $stable(acc_q))
    else $error("accumulator moved during hold");
  dir_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dir_chg |=> tmr_cnt == $past(ival))
    else $error("direction change did not reload timer");
  rate_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_act_q && io_upd && ctrl1_q[`RGEN_C1_RATE_RELOAD] |=> tmr_cnt == $past(ival))
    else $error("update did not reload timer");
  limit_clamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == RGEN_ST_RUN && !hold_s && lower_q <= upper_q ##1
      st_q == RGEN_ST_RUN && $stable(lower_q) && $stable(upper_q)
      |-> acc_q <= upper_q && acc_q >= lower_q)
    else $error("ramp outside limits");
  enable_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !io_upd |=> $stable(en_act_q))
    else $error("enable changed without update");
  clear_lower_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == RGEN_ST_CLEAR |=> acc_q == $past(lower_q))
    else $error("clear did not preset lower limit");
  dir_slope_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == RGEN_ST_RUN && expire && !hold_s && !dir_s && acc_q >= lower_q
      |=> acc_q <= $past(acc_q))
    else $error("low direction pin did not ramp down");
endmodule : rgen_ramp

// >>> verilog/rgen_step_timer.sv
`timescale 1ns/1ps
module rgen_step_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control.
  input  wire logic         tick,
  input  wire logic         hold,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Expiry pulse and remaining count.
  output logic              expire_q,
  output logic [W-1:0]      cnt_q
);
  if (W < 2) begin : g_chk
    $error("rgen_step_timer: W must be at least 2");
  end

  // A zero interval is served as one core cycle rather than a stuck timer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= '0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (load) begin
        cnt_q <= load_val;
      end else if (tick && !hold) begin
        if (cnt_q <= W'(1)) begin
          expire_q <= 1'b1;
          cnt_q    <= load_val;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  timer_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load |=> cnt_q == $past(load_val))
    else $error("timer did not take reload value");
endmodule : rgen_step_timer
